// ### design/ldrsc_pkg.sv
// constants, types and decode helpers for the local dram, refresh and shadow controller
package ldrsc_pkg;

  // ==========================================================================
  // i/o ports and configuration indexes
  localparam logic [15:0] IO_INDEX_PORT = 16'h0022;
  localparam logic [15:0] IO_DATA_PORT  = 16'h0024;
  localparam logic [15:0] IO_PORTB      = 16'h0061;
  localparam logic [7:0]  IDX_CTRL      = 8'h21;
  localparam logic [7:0]  IDX_BANK      = 8'h24;
  localparam logic [7:0]  IDX_PERF      = 8'h25;
  localparam logic [7:0]  IDX_SHADOW    = 8'h26;
  localparam logic [7:0]  IDX_CACHE     = 8'h27;
  localparam logic [7:0]  IDX_SHADOW_CD = 8'h2A;
  localparam logic [7:0]  IDX_STATUS    = 8'h2F;
  localparam logic [7:0]  IDX_NONE      = 8'hFF;
  localparam logic [3:0]  IDX_GROUP     = 4'h2;
  localparam logic [15:0] CFG_WR_MASK   = 16'h04F2;

  // ==========================================================================
  // field positions and reset values
  localparam int PARITY_EN_BIT  = 5;
  localparam int BANK_MSB       = 7;
  localparam int BANK_LSB       = 4;
  localparam int HIDDEN_BIT     = 7;
  localparam int WP_BIT         = 7;
  localparam int FSEG_SHADOW    = 4;
  localparam int VIDEO_CACHE    = 4;
  localparam int PORTB_PAR_LO   = 2;
  localparam int PORTB_PAR_HI   = 3;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] PORTB_RESET = 8'h00;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ           = 25;
  localparam int REFRESH_PERIOD_NS = 15000;
  localparam int REFRESH_CYCLES    = REFRESH_PERIOD_NS * CLK_MHZ / 1000;
  localparam logic [8:0] TMR_RELOAD = 9'(REFRESH_CYCLES - 1);
  localparam logic [2:0] AT_RFSH_CYCLES = 3'h4;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {PART_256K, PART_1M, PART_4M, PART_16M} ldrsc_part_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_ROW = 3'h1, ST_COL = 3'h3, ST_CAS = 3'h2,
    ST_PRE = 3'h6, ST_CBR_C = 3'h7, ST_CBR_R = 3'h5, ST_HOLDW = 3'h4
  } ldrsc_state_e;
  typedef struct packed {
    logic        ok;
    logic        two;
    ldrsc_part_e p0;
    ldrsc_part_e p1;
  } ldrsc_bank_s;
  typedef struct packed {
    logic        wr;
    logic [25:2] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } ldrsc_req_s;
  typedef struct packed {
    logic [11:0] ma;
    logic [1:0]  ras_n;
    logic [3:0]  cas_n;
    logic        we_n;
    logic [31:0] wdata;
    logic [3:0]  wpar;
  } ldrsc_dram_s;

  function automatic ldrsc_bank_s ldrsc_bank_decode(input logic [3:0] code);
    unique case (code)
      4'h0:    return '{1'b1, 1'b0, PART_256K, PART_256K};
      4'h1:    return '{1'b1, 1'b1, PART_256K, PART_256K};
      4'h8:    return '{1'b1, 1'b0, PART_1M, PART_1M};
      4'h2:    return '{1'b1, 1'b1, PART_256K, PART_1M};
      4'h9:    return '{1'b1, 1'b1, PART_1M, PART_1M};
      4'hC:    return '{1'b1, 1'b0, PART_4M, PART_4M};
      4'hA:    return '{1'b1, 1'b1, PART_1M, PART_4M};
      4'hB:    return '{1'b1, 1'b1, PART_4M, PART_1M};
      4'hD:    return '{1'b1, 1'b1, PART_4M, PART_4M};
      4'hE:    return '{1'b1, 1'b0, PART_16M, PART_16M};
      default: return '{1'b0, 1'b0, PART_256K, PART_256K};
    endcase
  endfunction

endpackage

// ### design/ldrsc_top.sv
// local page-mode dram controller with refresh, parity, shadow ram and rom select
// ============================================================================
`timescale 1ns/1ns
`default_nettype none

module ldrsc_top
  import ldrsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        mem_req,
  input  wire ldrsc_req_s  mem_in,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata,
  output logic             mem_parity_error,
  output logic             mem_cacheable,
  output logic             at_cycle_req,
  input  wire logic        at_bus_busy,
  output logic             bios_rom_select_n,
  output logic             cpu_hold,
  input  wire logic        cpu_hlda,
  output ldrsc_dram_s      dram,
  input  wire logic [31:0] dram_rdata,
  input  wire logic [3:0]  dram_rpar,
  output logic             at_refresh_n,
  output logic             at_memr_n,
  output logic      [7:0]  at_refresh_addr,
  input  wire logic        isa_master_refresh_n,
  output logic             refresh_timer_output,
  output logic             nmi
);

  // ==========================================================================
  // configuration port
  logic [7:0] idx_q;
  logic [7:0] cfg_q [16];
  logic [7:0] portb_q;
  logic [7:0] status;
  logic [7:0] rd_val;
  wire        io_idx_wr = io_wr && (io_addr == IO_INDEX_PORT);
  wire        io_dat_wr = io_wr && (io_addr == IO_DATA_PORT);
  wire        io_dat_rd = io_rd && (io_addr == IO_DATA_PORT);
  wire        io_pb_wr  = io_wr && (io_addr == IO_PORTB);
  wire        io_pb_rd  = io_rd && (io_addr == IO_PORTB);
  wire        idx_in    = idx_q[7:4] == IDX_GROUP;
  wire        idx_rw    = idx_in && CFG_WR_MASK[idx_q[3:0]];

  // index falls back to none after each data access, so every access re-indexes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= IDX_NONE;
    end else if (ce) begin
      if (io_idx_wr) begin
        idx_q <= io_wdata;
      end else if (io_dat_wr || io_dat_rd) begin
        idx_q <= IDX_NONE;
      end
    end
  end

  for (genvar i = 0; i < 16; i++) begin : g_cfg
    if (CFG_WR_MASK[i]) begin : g_rw
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_q[i] <= REG_RESET;
        end else if (ce && io_dat_wr && idx_in && (idx_q[3:0] == 4'(i))) begin
          cfg_q[i] <= io_wdata;
        end
      end
    end else begin : g_ro
      assign cfg_q[i] = REG_RESET;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portb_q <= PORTB_RESET;
    end else if (ce && io_pb_wr) begin
      portb_q <= io_wdata;
    end
  end

  assign rd_val = io_pb_rd ? portb_q :
                  (idx_q == IDX_STATUS) ? status :
                  idx_rw ? cfg_q[idx_q[3:0]] : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else if (ce && (io_dat_rd || io_pb_rd)) begin
      io_rdata <= rd_val;
    end
  end

  // ==========================================================================
  // decode of the current address
  ldrsc_state_e st_q, st_d;
  ldrsc_req_s   lat_q;
  ldrsc_bank_s  bank;
  ldrsc_part_e  part;
  logic [11:0]  row_ma;
  logic [11:0]  col_ma;
  logic [15:0]  shadow_vec;
  wire  [25:0]  a = {((st_q == ST_IDLE) ? mem_in.addr : lat_q.addr), 2'b00};
  wire          hidden  = cfg_q[IDX_PERF[3:0]][HIDDEN_BIT];
  assign bank = ldrsc_bank_decode(cfg_q[IDX_BANK[3:0]][BANK_MSB:BANK_LSB]);
  // bank0 span per part: 1, 4, 16 or 64MB
  wire b0_over = (bank.p0 == PART_256K) ? (a[25:20] != 6'h00) :
                 (bank.p0 == PART_1M)   ? (a[25:22] != 4'h0)  :
                 (bank.p0 == PART_4M)   ? (a[25:24] != 2'h0)  : 1'b0;
  wire sel1    = bank.two && b0_over;
  assign part  = sel1 ? bank.p1 : bank.p0;
  assign col_ma = {(part == PART_16M) ? a[24] : 1'b0,
                   (part >= PART_4M) ? a[12] : 1'b0,
                   (part >= PART_1M) ? a[11] : 1'b0,
                   a[10:2]};
  assign row_ma = {a[25], a[22], a[21],
                   (part == PART_256K) ? a[11] : a[20],
                   a[19:13],
                   (part <= PART_1M) ? a[12] : a[23]};

  // 16KB regions C0000h-EFFFFh, F segment as one enable
  assign shadow_vec = {{4{cfg_q[IDX_SHADOW[3:0]][FSEG_SHADOW]}},
                       cfg_q[IDX_SHADOW[3:0]][3:0], cfg_q[IDX_SHADOW_CD[3:0]]};
  wire in_rom   = (a[25:20] == 6'h00) && (a[19:18] == 2'b11);
  wire in_video = (a[25:20] == 6'h00) && (a[19:17] == 3'b101);
  wire shadowed = in_rom && shadow_vec[a[17:14]];
  wire is_local = !in_video && !(in_rom && !shadowed);
  // bios shadow always read-only, adapters per write protect
  wire wr_ignored = mem_in.wr && shadowed &&
                    ((a[17:16] == 2'b11) || cfg_q[IDX_SHADOW[3:0]][WP_BIT]);
  // E and F segments select the rom when not redirected
  wire rom_hit  = in_rom && !shadowed && a[17];
  // video shadow below C8000h may be cached
  wire vid_cache = shadowed && (a[17:15] == 3'b000) && cfg_q[IDX_CACHE[3:0]][VIDEO_CACHE];

  // ==========================================================================
  // refresh sources
  logic [8:0] tmr_q;
  logic [2:0] isa_sync_q;
  logic       isa_flt_q;
  logic       loc_pend_q;
  logic       at_pend_q;
  logic       rfsh_q;
  logic [2:0] at_cnt_q;
  logic [2:0] at_cnt_d;
  wire        tmr_fire = (tmr_q == 9'h000);
  wire        isa_agree = isa_sync_q[1] == isa_sync_q[2];
  wire        isa_fall  = isa_agree && isa_flt_q && !isa_sync_q[2];
  wire        at_active = at_cnt_q != 3'h0;

  // rate generator, one pulse per refresh period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= TMR_RELOAD;
    end else if (ce) begin
      tmr_q <= tmr_fire ? TMR_RELOAD : tmr_q - 9'h001;
    end
  end

  // a master that refreshes the bus also triggers our local refresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isa_sync_q <= 3'h7;
      isa_flt_q  <= 1'b1;
    end else if (ce) begin
      isa_sync_q <= {isa_sync_q[1:0], isa_master_refresh_n};
      if (isa_agree) begin
        isa_flt_q <= isa_sync_q[2];
      end
    end
  end

  // ==========================================================================
  // access arbitration
  wire idle    = st_q == ST_IDLE;
  wire can_req = idle && mem_req && !mem_ack;
  // local refresh wins the dram; bus cycles ignore the pending flag but wait while its states run
  wire loc_go  = can_req && is_local && !wr_ignored && !loc_pend_q;
  wire ign_go  = can_req && is_local && wr_ignored && !loc_pend_q;
  wire off_want = can_req && !is_local;
  // a bus cycle waits while the bus refresh runs
  wire off_go  = off_want && !at_active;
  wire hold_ok = (st_q == ST_HOLDW) && cpu_hlda;
  // hidden mode starts bus refresh on its own bus arbitration
  wire at_start = at_pend_q && !at_active &&
                  (hidden ? (!at_bus_busy && !off_want) : hold_ok);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (loc_pend_q) begin
          // normal mode asks for hold first, hidden goes straight in
          st_d = hidden ? ST_CBR_C : ST_HOLDW;
        end else if (loc_go) begin
          st_d = ST_ROW;
        end
      end
      ST_HOLDW: st_d = cpu_hlda ? ST_CBR_C : ST_HOLDW;
      ST_ROW:   st_d = ST_COL;
      ST_COL:   st_d = ST_CAS;
      ST_CAS:   st_d = ST_PRE;
      ST_CBR_C: st_d = ST_CBR_R;
      ST_CBR_R: st_d = ST_PRE;
      ST_PRE:   st_d = ST_IDLE;
    endcase
  end

  assign at_cnt_d = at_start ? AT_RFSH_CYCLES : (at_active ? at_cnt_q - 3'h1 : 3'h0);

  // pending refresh flags: a new request wins over the clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= ST_IDLE;
      loc_pend_q <= 1'b0;
      at_pend_q  <= 1'b0;
      rfsh_q     <= 1'b0;
      at_cnt_q   <= 3'h0;
      lat_q      <= '0;
    end else if (ce) begin
      st_q       <= st_d;
      loc_pend_q <= tmr_fire || isa_fall || (loc_pend_q && (st_q != ST_CBR_C));
      at_pend_q  <= tmr_fire || (at_pend_q && !at_start);
      rfsh_q     <= (st_d == ST_CBR_C) || (rfsh_q && (st_q != ST_PRE));
      at_cnt_q   <= at_cnt_d;
      if (loc_go) begin
        lat_q <= mem_in;
      end
    end
  end

  // ==========================================================================
  // dram pins
  ldrsc_dram_s dram_d;
  logic [3:0]  wpar;
  logic [3:0]  rpar_bad;
  logic [1:0]  ras_sel;
  for (genvar b = 0; b < 4; b++) begin : g_par
    assign wpar[b]     = ~^lat_q.wdata[8*b +: 8];
    assign rpar_bad[b] = (~^dram_rdata[8*b +: 8]) != dram_rpar[b];
  end
  assign ras_sel = !bank.ok ? 2'b11 : (sel1 ? 2'b01 : 2'b10);

  always_comb begin
    dram_d       = dram;
    dram_d.ras_n = 2'b11;
    dram_d.cas_n = 4'hF;
    dram_d.we_n  = 1'b1;
    unique case (st_d)
      ST_ROW: dram_d.ma = row_ma;
      ST_COL: begin
        dram_d.ma    = col_ma;
        dram_d.ras_n = ras_sel;
      end
      ST_CAS: begin
        dram_d.ras_n = ras_sel;
        dram_d.cas_n = lat_q.wr ? ~lat_q.be : 4'h0;
        dram_d.we_n  = !lat_q.wr;
        dram_d.wdata = lat_q.wdata;
        dram_d.wpar  = wpar;
      end
      ST_CBR_C: dram_d.cas_n = 4'h0;
      ST_CBR_R: begin
        dram_d.cas_n = 4'h0;
        dram_d.ras_n = 2'b00;
      end
      ST_IDLE, ST_HOLDW, ST_PRE: dram_d.ras_n = 2'b11;
    endcase
  end

  // ==========================================================================
  // answers to the cpu
  logic perr_q;
  wire  done_acc  = (st_q == ST_PRE) && !rfsh_q;
  wire  perr_hit  = done_acc && !lat_q.wr && perr_q;
  wire  par_en    = cfg_q[IDX_CTRL[3:0]][PARITY_EN_BIT];
  // port B bits at zero enable the check, as on the classic system port
  wire  portb_en  = portb_q[PORTB_PAR_HI:PORTB_PAR_LO] == 2'b00;
  wire  nmi_clr   = io_pb_wr && (io_wdata[PORTB_PAR_HI:PORTB_PAR_LO] != 2'b00);

  assign status = {4'h0, at_active, cpu_hold, nmi, loc_pend_q};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dram                 <= '{ma: 12'h000, ras_n: 2'b11, cas_n: 4'hF, we_n: 1'b1,
                                wdata: 32'h0000_0000, wpar: 4'h0};
      perr_q               <= 1'b0;
      mem_ack              <= 1'b0;
      mem_rdata            <= 32'h0000_0000;
      mem_parity_error     <= 1'b0;
      mem_cacheable        <= 1'b0;
      at_cycle_req         <= 1'b0;
      bios_rom_select_n    <= 1'b1;
      cpu_hold             <= 1'b0;
      at_refresh_n         <= 1'b1;
      at_memr_n            <= 1'b1;
      at_refresh_addr      <= 8'h00;
      refresh_timer_output <= 1'b0;
      nmi                  <= 1'b0;
    end else if (ce) begin
      dram <= dram_d;
      if (st_q == ST_CAS && !lat_q.wr) begin
        perr_q    <= |rpar_bad;
        mem_rdata <= dram_rdata;
      end
      mem_ack              <= done_acc || ign_go || off_go;
      // error shown with the read answer
      mem_parity_error     <= perr_hit;
      if (loc_go || ign_go) begin
        mem_cacheable <= vid_cache;
      end
      at_cycle_req         <= off_go;
      bios_rom_select_n    <= !(off_go && rom_hit);
      // hold from request until local and bus refresh are both over
      cpu_hold             <= (st_d == ST_HOLDW) ||
                              (cpu_hold && (!idle || at_active || at_start));
      at_refresh_n         <= at_cnt_d == 3'h0;
      at_memr_n            <= at_cnt_d == 3'h0;
      if (at_active && at_cnt_d == 3'h0) begin
        at_refresh_addr <= at_refresh_addr + 8'h01;
      end
      refresh_timer_output <= tmr_fire;
      // gated nmi, set wins over clear
      nmi <= (perr_hit && par_en && portb_en) || (nmi && !nmi_clr);
    end
  end

  // ==========================================================================
  // checks
  logic [8:0] gap_q;
  logic       seen_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q  <= 9'h000;
      seen_q <= 1'b0;
    end else if (ce) begin
      gap_q  <= refresh_timer_output ? 9'h001 : gap_q + 9'h001;
      seen_q <= seen_q || refresh_timer_output;
    end
  end

  a_timer_gap: assert property (@(posedge clk) disable iff (!rst_n)
    ce && refresh_timer_output && seen_q |-> gap_q == 9'(REFRESH_CYCLES))
    else $error("refresh pulse spacing wrong");
  a_cbr_order: assert property (@(posedge clk) disable iff (!rst_n)
    ce && st_q == ST_CBR_C |-> (dram.ras_n == 2'b11 && dram.cas_n == 4'h0)
      ##1 (dram.ras_n == 2'b00 && dram.cas_n == 4'h0))
    else $error("local refresh not cas before ras");
  a_hold_normal: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cpu_hold) |-> !$past(hidden))
    else $error("hold raised in hidden refresh");
  a_write_parity: assert property (@(posedge clk) disable iff (!rst_n)
    !dram.we_n |-> dram.wpar == {~^dram.wdata[31:24], ~^dram.wdata[23:16],
                                 ~^dram.wdata[15:8], ~^dram.wdata[7:0]})
    else $error("write parity mismatch");
  a_col_map: assert property (@(posedge clk) disable iff (!rst_n)
    ce && st_q == ST_COL |=> dram.ma[8:0] == lat_q.addr[10:2])
    else $error("column address mapping wrong");
  a_row_map: assert property (@(posedge clk) disable iff (!rst_n)
    ce && st_q == ST_IDLE && loc_go |=> dram.ma[7:1] == lat_q.addr[19:13])
    else $error("row address mapping wrong");
  a_nmi_gate: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(nmi) |-> $past(par_en) && $past(portb_en) && $past(perr_hit))
    else $error("nmi without enables");
  a_bios_ro: assert property (@(posedge clk) disable iff (!rst_n)
    ce && ign_go |=> mem_ack ##0 dram.we_n[*3])
    else $error("protected shadow write reached dram");
  a_rom_sel: assert property (@(posedge clk) disable iff (!rst_n)
    !bios_rom_select_n |-> at_cycle_req && $past(rom_hit))
    else $error("rom select outside rom segments");

endmodule // ldrsc_top

`default_nettype wire

// ### dv/ldrsc_dram_model.sv
// page-mode dram array model on the far side of the controller
`timescale 1ns/1ns
`default_nettype none
module ldrsc_dram_model
  import ldrsc_pkg::*;
(
  input  wire logic        clk,
  input  wire ldrsc_dram_s dram,
  input  wire logic        corrupt,
  output logic      [31:0] dram_rdata,
  output logic      [3:0]  dram_rpar,
  output logic      [11:0] row_ma,
  output logic      [11:0] col_ma,
  output logic      [3:0]  last_wpar,
  output var int           writes,
  output var int           reads,
  output var int           cbr
);
  // ==========================================================================
  // array state
  logic [35:0] mem [logic [24:0]];
  logic [35:0] last = 36'h0;
  logic [35:0] tmp;
  logic [11:0] ma_p = 12'h000;
  logic [1:0]  ras_p = 2'h3;
  logic        cas_p = 1'b1;
  logic        bank = 1'b0;
  wire         cas_lo = ~&dram.cas_n;
  wire  [24:0] key = {bank, row_ma, dram.ma};
  // released lines show the inverse of the last value, never a stale copy
  always @(key or cas_lo or dram.we_n or corrupt or last) begin
    if (cas_lo && dram.we_n && mem.exists(key)) begin
      {dram_rpar, dram_rdata} = mem[key] ^ {3'h0, corrupt, 32'h0};
    end else begin
      {dram_rpar, dram_rdata} = ~last;
    end
  end
  always @(posedge clk) begin
    ras_p <= dram.ras_n;
    cas_p <= ~cas_lo;
    ma_p <= dram.ma;
    last <= {dram_rpar, dram_rdata};
    // refresh only when cas is already low at ras fall
    if ((ras_p & ~dram.ras_n) != 2'h0) begin
      cbr <= cbr + (cas_lo ? 1 : 0);
      if (!cas_lo) row_ma <= ma_p;
      if (!cas_lo) bank <= dram.ras_n[1];
    end
    // byte and parity stored per lane
    if (cas_p && cas_lo && dram.ras_n != 2'h3) begin
      col_ma <= dram.ma;
      tmp = mem.exists(key) ? mem[key] : 36'h0;
      for (int i = 0; i < 4; i++) begin
        if (!dram.cas_n[i]) tmp[8*i+:8] = dram.wdata[8*i+:8];
        if (!dram.cas_n[i]) tmp[32+i] = dram.wpar[i];
      end
      if (!dram.we_n) mem[key] = tmp;
      if (!dram.we_n) last_wpar <= dram.wpar;
      writes <= writes + (dram.we_n ? 0 : 1);
      reads <= reads + (dram.we_n ? 1 : 0);
    end
  end
endmodule // ldrsc_dram_model
`default_nettype wire

// ### dv/tb_local_dram_refresh_shadow_ctl.sv
// self-checking bench for the local dram, refresh and shadow controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_local_dram_refresh_shadow_ctl
  import ldrsc_pkg::*;
;
  // ==========================================================================
  // signals
  logic        clk = 1'b0, rst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0, mem_req = 1'b0;
  logic        cpu_hlda = 1'b0, corrupt = 1'b0, hold_seen = 1'b0, rom_seen = 1'b0, pe;
  logic        isa_rf_n = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0]  io_wdata = 8'h00, io_rdata, at_refresh_addr;
  logic [31:0] mem_rdata, dram_rdata, seed = 32'hA8EA1F2C;
  logic [3:0]  dram_rpar, last_wpar;
  logic [11:0] row_ma, col_ma;
  logic        mem_ack, mem_parity_error, mem_cacheable, at_cycle_req, bios_rom_select_n;
  logic        cpu_hold, at_refresh_n, at_memr_n, refresh_timer_output, nmi;
  ldrsc_req_s  mem_in = '0;
  ldrsc_dram_s dram;
  int          errors = 0, checked = 0, cyc = 0, rf_run = 0, rf_len = 0, writes, reads, cbr;
  ldrsc_top dut (.clk, .rst_n, .ce(1'b1), .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata,
    .mem_req, .mem_in, .mem_ack, .mem_rdata, .mem_parity_error, .mem_cacheable,
    .at_cycle_req, .at_bus_busy(1'b0), .bios_rom_select_n, .cpu_hold, .cpu_hlda, .dram,
    .dram_rdata, .dram_rpar, .at_refresh_n, .at_memr_n, .at_refresh_addr,
    .isa_master_refresh_n(isa_rf_n), .refresh_timer_output, .nmi);
  ldrsc_dram_model far (.clk, .dram, .corrupt, .dram_rdata, .dram_rpar, .row_ma, .col_ma,
    .last_wpar, .writes, .reads, .cbr);
  initial forever #20 clk = ~clk;
  // host cpu grants hold a cycle late; watchers for refresh and rom cycles
  always @(posedge clk) begin
    cpu_hlda <= cpu_hold;
    cyc <= cyc + 1;
    if (cpu_hold) hold_seen <= 1'b1;
    if (at_cycle_req && !bios_rom_select_n) rom_seen <= 1'b1;
    rf_run <= (!at_refresh_n && !at_memr_n) ? rf_run + 1 : 0;
    if (at_refresh_n && rf_run != 0) rf_len <= rf_run;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  // ==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] odd(input logic [31:0] d);
    for (int i = 0; i < 4; i++) odd[i] = ~^d[8*i+:8];
  endfunction
  // unmapped multiplexer bits are masked off, the part size decides how many count
  function automatic logic [23:0] exp_ma(input int p, input logic [25:0] a);
    logic [11:0] m;
    m = 12'hFFF >> (3 - p);
    return {a[25], a[22:21], p == 0 ? a[11] : a[20], a[19:13], p < 2 ? a[12] : a[23],
            a[24], a[12:2]} & {m, m};
  endfunction
  task automatic io(input logic rd, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_wr <= ~rd;
    io_rd <= rd;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
  endtask
  task automatic cfg(input logic [7:0] i, input logic [7:0] d);
    io(1'b0, IO_INDEX_PORT, i);
    io(1'b0, IO_DATA_PORT, d);
  endtask
  task automatic acc(input logic wr, input logic [25:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    mem_req <= 1'b1;
    mem_in <= '{wr, a[25:2], d, 4'hF};
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (mem_ack !== 1'b1 && n < 400);
    pe = mem_parity_error;
    if (mem_ack !== 1'b1) errors++;
    @(posedge clk);
    mem_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic tick();
    do begin
      @(posedge clk);
      #1;
    end while (refresh_timer_output !== 1'b1);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    logic [25:0] a;
    logic [31:0] d;
    int n, c0, w0;
    logic [7:0] ra;
    repeat (3) @(posedge clk);
    `CHK({cpu_hold, nmi, bios_rom_select_n, dram.ras_n, at_refresh_n}, 6'h0F)
    rst_n <= 1'b1;
    cfg(IDX_BANK, 8'hD0);
    cfg(IDX_PERF, 8'h40);
    io(1'b0, IO_INDEX_PORT, IDX_BANK);
    io(1'b1, IO_DATA_PORT, 8'h00);
    `CHK(io_rdata, 8'hD0)
    io(1'b0, IO_INDEX_PORT, IDX_PERF);
    io(1'b1, IO_DATA_PORT, 8'h00);
    `CHK(io_rdata, 8'h40)
    done("registers");
    for (int p = 0; p < 4; p++) begin
      cfg(IDX_BANK, {4'(4'hE << (3 - p)), 4'h0});
      for (int k = 0; k < 4; k++) begin
        a = 26'(rnd() & ((32'h100000 << (2 * p)) - 1) & 32'h3FFFFFC);
        a = (p == 0) ? a & 26'h7FFFC : a | 26'h100000;
        d = rnd();
        acc(1'b1, a, d);
        `CHK(last_wpar, odd(d))
        acc(1'b0, a, 32'h0);
        `CHK({mem_rdata, pe}, {d, 1'b0})
        `CHK({row_ma, col_ma} & exp_ma(p, 26'h3FFFFFF), exp_ma(p, a))
      end
    end
    done("mapping");
    corrupt = 1'b1;
    acc(1'b0, a, 32'h0);
    `CHK({pe, nmi}, 2'b10)
    cfg(IDX_CTRL, 8'h20);
    acc(1'b0, a, 32'h0);
    `CHK({pe, nmi}, 2'b11)
    io(1'b0, IO_PORTB, 8'h04);
    acc(1'b0, a, 32'h0);
    `CHK(nmi, 1'b0)
    corrupt = 1'b0;
    done("parity");
    tick();
    n = cyc;
    // let the refresh launched by this pulse finish before taking counts
    repeat (20) @(posedge clk);
    #1;
    hold_seen = 1'b0;
    c0 = cbr;
    ra = at_refresh_addr;
    tick();
    `CHK(cyc - n, 15000 / 40)
    repeat (20) @(posedge clk);
    #1;
    `CHK({hold_seen, 8'(at_refresh_addr - ra)}, 9'h101)
    `CHK(cbr - c0, 1)
    `CHK(rf_len, int'(AT_RFSH_CYCLES))
    cfg(IDX_PERF, 8'h80);
    tick();
    hold_seen = 1'b0;
    c0 = cbr;
    acc(1'b0, a, 32'h0);
    `CHK({mem_rdata, hold_seen}, {d, 1'b0})
    `CHK(cbr - c0, 1)
    c0 = cbr;
    // bus master supplies its own refresh pulse
    @(posedge clk);
    isa_rf_n <= 1'b0;
    repeat (8) @(posedge clk);
    isa_rf_n <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    `CHK(cbr - c0, 1)
    done("refresh");
    rom_seen = 1'b0;
    acc(1'b0, 26'hE0000, 32'h0);
    `CHK(rom_seen, 1'b1)
    rom_seen = 1'b0;
    acc(1'b0, 26'hC0000, 32'h0);
    `CHK(rom_seen, 1'b0)
    cfg(IDX_SHADOW, 8'h10);
    w0 = writes;
    c0 = reads;
    acc(1'b1, 26'hF0000, 32'h0);
    acc(1'b0, 26'hFC000, 32'h0);
    acc(1'b0, 26'hE4000, 32'h0);
    `CHK({writes - w0, reads - c0}, {32'd0, 32'd1})
    `CHK(rom_seen, 1'b1)
    cfg(IDX_SHADOW_CD, 8'h01);
    cfg(IDX_SHADOW, 8'h90);
    w0 = writes;
    acc(1'b1, 26'hC0000, ~d);
    cfg(IDX_SHADOW, 8'h10);
    // shadow image written before it is relied on
    acc(1'b1, 26'hC0000, d);
    `CHK(writes - w0, 1)
    cfg(IDX_CACHE, 8'h10);
    acc(1'b0, 26'hC0000, 32'h0);
    `CHK({mem_rdata, mem_cacheable}, {d, 1'b1})
    cfg(IDX_CACHE, 8'h00);
    acc(1'b0, 26'hC0000, 32'h0);
    `CHK(mem_cacheable, 1'b0)
    done("shadow");
    complete_run();
  end
endmodule // tb_local_dram_refresh_shadow_ctl
`default_nettype wire
